//--- core/can_moh_params.svh
// constants for the message object handler
// How it works
// R1: with shift register ready and no interface transfer, load best pending valid object
// R2: loading an object clears its new data flag, seen in the summary output
// R3: after success, clear tx request unless object was rewritten since transmit start
// R4: with tx irq enable, successful transmit sets the object's irq pending bit
// R5: lost arbitration or error retransmits later, higher priority requests go first
// R6: software sets up transmit objects valid, last flag, transmit, flags cleared
// R7: standard identifier lives in arbitration bits 28:18, lower bits ignored
// R8: remote frame on transmit object with remote answer enable sets tx request only
// R9: acceptance mask selects compared bits; extended-only mask bit rejects standard frames
// R10: software sets length code and data valid before tx request or remote enable
// R11: transmit object data may be updated any time through interface registers
// R12: each data register moves whole; software makes all four bytes valid first
// R13: data update with new data command sets data and tx request together
// R14: new data set with tx request survives running transmit, cleared at next start
// R15: received header is compared object by object from object 1, first match wins
// R16: accepted data frame stores data, arbitration, length and sets new data flag
// R17: storing over set new data flag sets message lost
// R18: rx irq enable sets irq pending of receiving object; software clears flags
// R19: remote frame on transmit object, no remote enable, no mask: ignored
// R20: same but masked: clear tx request, store header, set new data, keep data
// R21: object number is priority, lowest number transmits first
// R22: message memory holds 32 identical objects reached only through interface sets
// R23: two identical independent interface register sets
// R24: memory accesses from interfaces, transmit and receive are serialised
`ifndef CAN_MOH_PARAMS_SVH
`define CAN_MOH_PARAMS_SVH

`define NUM_OBJ      32
// command mask bits
`define CMD_WR       7
`define CMD_MASK     6
`define CMD_ARB      5
`define CMD_CTL      4
`define CMD_CLRINT   3
`define CMD_TXNEW    2
`define CMD_DLO      1
`define CMD_DHI      0
// arbitration word bits
`define ARB_VAL      31
`define ARB_XTD      30
`define ARB_DIR      29
// mask word bits
`define MSK_XTD      31
// control word bits
`define CTL_NEW      15
`define CTL_LOST     14
`define CTL_IRQ      13
`define CTL_USE_ACCEPTANCE_MASK    12
`define CTL_TX_IRQ_ENABLE     11
`define CTL_RX_IRQ_ENABLE     10
`define CTL_RMT      9
`define CTL_TXRQ     8
`define CTL_EOB      7
// standard identifier bits inside the 29 bit field
`define STD_ID_MASK  29'h1ffc_0000

`endif

//--- core/can_moh_pkg.sv
// types of the message object handler
package can_moh_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_SCAN, RX_STORE} rx_state_t;
endpackage

//--- core/obj_priority.sv
// lowest numbered request finder
`timescale 1ns/1ps
module obj_priority #(
	parameter int N = 32,
	parameter int W = 5
) (
	input  wire logic [N-1:0] req,
	output logic              found,
	output logic [W-1:0]      idx
);
	// scan from the top so the lowest set bit is left standing
	always_comb
	begin
		found = 1'b0;
		idx   = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				found = 1'b1;
				idx   = W'(i);
			end
		end
	end
endmodule // obj_priority

//--- core/ifc_regs.sv
// one interface register set between software and message memory
`timescale 1ns/1ps
`include "can_moh_params.svh"
module ifc_regs (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        arb_we,
	input  wire logic [31:0] arb_wdata,
	input  wire logic        mask_we,
	input  wire logic [31:0] mask_wdata,
	input  wire logic        ctl_we,
	input  wire logic [15:0] ctl_wdata,
	input  wire logic        dlo_we,
	input  wire logic [31:0] dlo_wdata,
	input  wire logic        dhi_we,
	input  wire logic [31:0] dhi_wdata,
	input  wire logic        cmd_we,
	input  wire logic [7:0]  cmd_wdata,
	input  wire logic        req_we,
	input  wire logic [5:0]  req_num,
	input  wire logic        ack,
	input  wire logic [31:0] rd_arb,
	input  wire logic [31:0] rd_mask,
	input  wire logic [15:0] rd_ctl,
	input  wire logic [63:0] rd_data,
	output logic      [31:0] arb_q,
	output logic      [31:0] mask_q,
	output logic      [15:0] ctl_q,
	output logic      [31:0] dlo_q,
	output logic      [31:0] dhi_q,
	output logic      [7:0]  cmd_q,
	output logic             busy_q,
	output logic      [4:0]  obj_q
);
	wire sw_ok  = !busy_q; // buffers frozen while a transfer waits
	wire num_ok = (req_num != 6'h00) && (req_num <= 6'(`NUM_OBJ));
	wire cap    = ack && !cmd_q[`CMD_WR];

	// buffer registers: memory read wins over software write
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			arb_q  <= '0;
			mask_q <= '0;
			ctl_q  <= '0;
			dlo_q  <= '0;
			dhi_q  <= '0;
			cmd_q  <= '0;
		end
		else
		begin
			if (cap && cmd_q[`CMD_ARB]) arb_q <= rd_arb;
			else if (arb_we && sw_ok) arb_q <= arb_wdata;
			if (cap && cmd_q[`CMD_MASK]) mask_q <= rd_mask;
			else if (mask_we && sw_ok) mask_q <= mask_wdata;
			if (cap && cmd_q[`CMD_CTL]) ctl_q <= rd_ctl;
			else if (ctl_we && sw_ok) ctl_q <= ctl_wdata;
			if (cap && cmd_q[`CMD_DLO]) dlo_q <= rd_data[31:0]; // whole word [R12]
			else if (dlo_we && sw_ok) dlo_q <= dlo_wdata;
			if (cap && cmd_q[`CMD_DHI]) dhi_q <= rd_data[63:32]; // [R12]
			else if (dhi_we && sw_ok) dhi_q <= dhi_wdata;
			if (cmd_we && sw_ok) cmd_q <= cmd_wdata;
		end
	end

	// request: numbers outside 1..32 are dropped
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			busy_q <= 1'b0;
			obj_q  <= '0;
		end
		else if (ack)
			busy_q <= 1'b0;
		else if (req_we && sw_ok && num_ok)
		begin
			busy_q <= 1'b1;
			obj_q  <= 5'(req_num - 6'h01);
		end
	end
endmodule // ifc_regs

//--- core/can_msg_handler.sv
// message handler with message memory, two interface sets, tx and rx paths
`timescale 1ns/1ps
`include "can_moh_params.svh"
module can_msg_handler #(
	parameter int N_OBJ = `NUM_OBJ,
	parameter int IW    = 5
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic [1:0]        if_arb_we,
	input  wire logic [1:0][31:0]  if_arb_wdata,
	input  wire logic [1:0]        if_mask_we,
	input  wire logic [1:0][31:0]  if_mask_wdata,
	input  wire logic [1:0]        if_ctl_we,
	input  wire logic [1:0][15:0]  if_ctl_wdata,
	input  wire logic [1:0]        if_dlo_we,
	input  wire logic [1:0][31:0]  if_dlo_wdata,
	input  wire logic [1:0]        if_dhi_we,
	input  wire logic [1:0][31:0]  if_dhi_wdata,
	input  wire logic [1:0]        if_cmd_we,
	input  wire logic [1:0][7:0]   if_cmd_wdata,
	input  wire logic [1:0]        if_req_we,
	input  wire logic [1:0][5:0]   if_req_num,
	output logic      [1:0][31:0]  if_arb,
	output logic      [1:0][31:0]  if_mask,
	output logic      [1:0][15:0]  if_ctl,
	output logic      [1:0][31:0]  if_dlo,
	output logic      [1:0][31:0]  if_dhi,
	output logic      [1:0][7:0]   if_cmd,
	output logic      [1:0]        if_busy,
	input  wire logic              tx_ready,
	input  wire logic              tx_ok,
	input  wire logic              tx_fail,
	output logic                   tx_load_q,
	output logic      [28:0]       tx_id_q,
	output logic                   tx_xtd_q,
	output logic                   tx_rtr_q,
	output logic      [3:0]        tx_dlc_q,
	output logic      [63:0]       tx_data_q,
	input  wire logic              rx_valid,
	input  wire logic [28:0]       rx_id,
	input  wire logic              rx_xtd,
	input  wire logic              rx_rtr,
	input  wire logic [3:0]        rx_dlc,
	input  wire logic [63:0]       rx_data,
	output logic      [N_OBJ-1:0]  new_data_summary,
	output logic      [N_OBJ-1:0]  tx_request_summary,
	output logic      [N_OBJ-1:0]  irq_pending_summary,
	output logic      [N_OBJ-1:0]  message_lost_summary,
	output logic      [N_OBJ-1:0]  object_valid_summary
);
	// message memory: wide fields as arrays, flags as vectors [R22]
	logic [28:0]      id_m   [N_OBJ];
	logic [28:0]      msk_m  [N_OBJ];
	logic [3:0]       dlc_m  [N_OBJ];
	logic [63:0]      data_m [N_OBJ];
	logic [N_OBJ-1:0] object_valid_q, xtd_q, dir_q, mxtd_q, use_acceptance_mask_q, tx_irq_enable_q, rx_irq_enable_q;
	logic [N_OBJ-1:0] remote_answer_enable_q, eob_q, new_data_flag_q, message_lost_q, irq_pending_q, tx_request_q;

	logic [1:0][4:0]  if_obj;
	logic [1:0]       if_ack;
	logic [31:0]      rd_arb, rd_mask;
	logic [15:0]      rd_ctl;

	logic             tx_busy_q, tx_dirty_q;
	logic [IW-1:0]    tx_obj_q;
	logic             pick_found;
	logic [IW-1:0]    pick;

	can_moh_pkg::rx_state_t rx_state_q;
	logic [IW-1:0]    scan_q, hit_q;
	logic [28:0]      rid_q;
	logic             rxtd_q, rrtr_q;
	logic [3:0]       rdlc_q;
	logic [63:0]      rdata_q;

	// two identical interface sets [R23]
	genvar k;
	generate
		for (k = 0; k < 2; k++)
		begin : g_ifc
			ifc_regs u_ifc (
				.clk       (clk),
				.reset_n   (reset_n),
				.arb_we    (if_arb_we[k]),
				.arb_wdata (if_arb_wdata[k]),
				.mask_we   (if_mask_we[k]),
				.mask_wdata(if_mask_wdata[k]),
				.ctl_we    (if_ctl_we[k]),
				.ctl_wdata (if_ctl_wdata[k]),
				.dlo_we    (if_dlo_we[k]),
				.dlo_wdata (if_dlo_wdata[k]),
				.dhi_we    (if_dhi_we[k]),
				.dhi_wdata (if_dhi_wdata[k]),
				.cmd_we    (if_cmd_we[k]),
				.cmd_wdata (if_cmd_wdata[k]),
				.req_we    (if_req_we[k]),
				.req_num   (if_req_num[k]),
				.ack       (if_ack[k]),
				.rd_arb    (rd_arb),
				.rd_mask   (rd_mask),
				.rd_ctl    (rd_ctl),
				.rd_data   (data_m[if_obj[k]]),
				.arb_q     (if_arb[k]),
				.mask_q    (if_mask[k]),
				.ctl_q     (if_ctl[k]),
				.dlo_q     (if_dlo[k]),
				.dhi_q     (if_dhi[k]),
				.cmd_q     (if_cmd[k]),
				.busy_q    (if_busy[k]),
				.obj_q     (if_obj[k])
			);
		end
	endgenerate

	// lowest numbered valid object with a request [R21]
	obj_priority #(.N(N_OBJ), .W(IW)) u_pick (
		.req  (tx_request_q & object_valid_q),
		.found(pick_found),
		.idx  (pick)
	);

	// acceptance compare of one object against the held header [R15]
	function automatic logic obj_match(input logic [IW-1:0] i);
		logic [28:0] m;
		logic        xok;
		m   = use_acceptance_mask_q[i] ? msk_m[i] : '1; // [R9]
		m   = rxtd_q ? m : (m & `STD_ID_MASK); // standard ids use 28:18 only [R7]
		xok = (use_acceptance_mask_q[i] && mxtd_q[i]) ? rxtd_q // extended only refuses standard [R9]
			: (use_acceptance_mask_q[i] || (xtd_q[i] == rxtd_q)); // [R9]
		return object_valid_q[i] && (rrtr_q ? dir_q[i] : !dir_q[i]) && xok
			&& (((id_m[i] ^ rid_q) & m) == 29'h0000_0000);
	endfunction

	// one memory action per cycle, fixed order [R24]
	wire act_txevt  = tx_ok && tx_busy_q;
	wire act_if1    = !act_txevt && if_busy[0];
	wire act_if2    = !act_txevt && !if_busy[0] && if_busy[1];
	wire act_if     = act_if1 || act_if2;
	wire act_rx     = !act_txevt && !act_if && rx_state_q == can_moh_pkg::RX_STORE;
	wire act_txload = !act_txevt && !act_if && !act_rx && tx_ready && !tx_busy_q
		&& pick_found && (if_busy == 2'b00); // [R1]
	assign if_ack = {act_if2, act_if1};

	// selected interface request
	wire [7:0]  c   = if_cmd[act_if2];
	wire [4:0]  o   = if_obj[act_if2];
	wire [31:0] wa  = if_arb[act_if2];
	wire [15:0] wc  = if_ctl[act_if2];
	wire        wr  = c[`CMD_WR];
	wire        hit_tx = tx_busy_q && (IW'(o) == tx_obj_q);

	// read words of the addressed object, old values before any clear
	assign rd_arb  = {object_valid_q[o], xtd_q[o], dir_q[o], id_m[o]};
	assign rd_mask = {mxtd_q[o], 2'b00, msk_m[o]};
	assign rd_ctl  = {new_data_flag_q[o], message_lost_q[o], irq_pending_q[o], use_acceptance_mask_q[o], tx_irq_enable_q[o],
		rx_irq_enable_q[o], remote_answer_enable_q[o], tx_request_q[o], eob_q[o], 3'b000, dlc_m[o]};

	assign new_data_summary     = new_data_flag_q;
	assign tx_request_summary   = tx_request_q;
	assign irq_pending_summary  = irq_pending_q;
	assign message_lost_summary = message_lost_q;
	assign object_valid_summary = object_valid_q;

	// wide fields: no reset, guarded by object_valid
	always_ff @(posedge clk)
	begin
		if (act_if && wr)
		begin
			if (c[`CMD_ARB]) id_m[o] <= wa[28:0];
			if (c[`CMD_MASK]) msk_m[o] <= if_mask[act_if2][28:0];
			if (c[`CMD_CTL]) dlc_m[o] <= wc[3:0];
			if (c[`CMD_DLO]) data_m[o][31:0] <= if_dlo[act_if2]; // any time [R11][R12]
			if (c[`CMD_DHI]) data_m[o][63:32] <= if_dhi[act_if2]; // [R11][R12]
		end
		if (act_rx && (!rrtr_q || (!remote_answer_enable_q[hit_q] && use_acceptance_mask_q[hit_q])))
		begin
			id_m[hit_q]  <= rxtd_q ? rid_q : (rid_q & `STD_ID_MASK); // [R16][R20]
			dlc_m[hit_q] <= rdlc_q;
			if (!rrtr_q) data_m[hit_q] <= rdata_q; // data kept for remote [R16][R20]
		end
	end

	// flag vectors
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			{object_valid_q, xtd_q, dir_q, mxtd_q, use_acceptance_mask_q, tx_irq_enable_q, rx_irq_enable_q} <= '0;
			{remote_answer_enable_q, eob_q, new_data_flag_q, message_lost_q, irq_pending_q, tx_request_q} <= '0;
		end
		else
		begin
			if (act_txevt)
			begin
				if (!tx_dirty_q) tx_request_q[tx_obj_q] <= 1'b0; // [R3]
				if (tx_irq_enable_q[tx_obj_q]) irq_pending_q[tx_obj_q] <= 1'b1; // [R4]
			end
			if (act_txload) new_data_flag_q[pick] <= 1'b0; // [R2][R14]
			if (act_if && wr)
			begin
				if (c[`CMD_ARB])
					{object_valid_q[o], xtd_q[o], dir_q[o]} <= wa[`ARB_VAL:`ARB_DIR];
				if (c[`CMD_MASK]) mxtd_q[o] <= if_mask[act_if2][`MSK_XTD];
				if (c[`CMD_CTL])
				begin
					{new_data_flag_q[o], message_lost_q[o], irq_pending_q[o]} <= wc[`CTL_NEW:`CTL_IRQ];
					{use_acceptance_mask_q[o], tx_irq_enable_q[o], rx_irq_enable_q[o]} <= wc[`CTL_USE_ACCEPTANCE_MASK:`CTL_RX_IRQ_ENABLE];
					{remote_answer_enable_q[o], tx_request_q[o], eob_q[o]} <= wc[`CTL_RMT:`CTL_EOB];
				end
				if (c[`CMD_TXNEW])
				begin
					tx_request_q[o] <= 1'b1; // data and request together [R13]
					new_data_flag_q[o] <= 1'b1; // [R14]
				end
			end
			else if (act_if)
			begin
				if (c[`CMD_CLRINT]) irq_pending_q[o] <= 1'b0;
				if (c[`CMD_TXNEW]) new_data_flag_q[o] <= 1'b0;
			end
			if (act_rx && !rrtr_q)
			begin
				xtd_q[hit_q]    <= rxtd_q; // [R16]
				new_data_flag_q[hit_q] <= 1'b1; // [R16]
				tx_request_q[hit_q] <= 1'b0; // pending remote request is answered
				if (new_data_flag_q[hit_q]) message_lost_q[hit_q] <= 1'b1; // [R17]
				if (rx_irq_enable_q[hit_q]) irq_pending_q[hit_q] <= 1'b1; // [R18]
			end
			else if (act_rx && remote_answer_enable_q[hit_q])
				tx_request_q[hit_q] <= 1'b1; // rest untouched [R8]
			else if (act_rx && use_acceptance_mask_q[hit_q])
			begin
				tx_request_q[hit_q] <= 1'b0; // [R20]
				xtd_q[hit_q]    <= rxtd_q; // [R20]
				new_data_flag_q[hit_q] <= 1'b1; // [R20]
			end
			// masked off remote on plain transmit object changes nothing [R19]
		end
	end

	// transmit side: load, then wait for result from the protocol controller
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			tx_busy_q  <= 1'b0;
			tx_dirty_q <= 1'b0;
			tx_obj_q   <= '0;
			tx_load_q  <= 1'b0;
			tx_id_q    <= '0;
			tx_xtd_q   <= 1'b0;
			tx_rtr_q   <= 1'b0;
			tx_dlc_q   <= '0;
			tx_data_q  <= '0;
		end
		else
		begin
			tx_load_q <= act_txload; // [R1]
			if (act_txload)
			begin
				tx_busy_q  <= 1'b1;
				tx_dirty_q <= 1'b0;
				tx_obj_q   <= pick; // [R21]
				tx_id_q    <= id_m[pick];
				tx_xtd_q   <= xtd_q[pick];
				tx_rtr_q   <= !dir_q[pick]; // receive object sends a remote frame
				tx_dlc_q   <= dlc_m[pick];
				tx_data_q  <= data_m[pick];
			end
			else if (act_txevt || (tx_fail && tx_busy_q))
				tx_busy_q <= 1'b0; // request stays set on failure, repicked by priority [R5]
			if (act_if && wr && hit_tx
				&& (c[`CMD_DLO] || c[`CMD_DHI] || c[`CMD_TXNEW] || c[`CMD_CTL]))
				tx_dirty_q <= 1'b1; // [R3][R14]
		end
	end

	// receive side: hold header, scan objects, then wait for a memory slot
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			rx_state_q <= can_moh_pkg::RX_IDLE;
			scan_q     <= '0;
			hit_q      <= '0;
			rid_q      <= '0;
			rxtd_q     <= 1'b0;
			rrtr_q     <= 1'b0;
			rdlc_q     <= '0;
			rdata_q    <= '0;
		end
		else
		begin
			unique case (rx_state_q)
				can_moh_pkg::RX_IDLE:
					if (rx_valid)
					begin
						rid_q      <= rx_id;
						rxtd_q     <= rx_xtd;
						rrtr_q     <= rx_rtr;
						rdlc_q     <= rx_dlc;
						rdata_q    <= rx_data;
						scan_q     <= '0; // start at object 1 [R15]
						rx_state_q <= can_moh_pkg::RX_SCAN;
					end
				can_moh_pkg::RX_SCAN:
					if (obj_match(scan_q))
					begin
						hit_q      <= scan_q; // first match stops the scan [R15]
						rx_state_q <= can_moh_pkg::RX_STORE;
					end
					else if (scan_q == IW'(N_OBJ - 1))
						rx_state_q <= can_moh_pkg::RX_IDLE; // no object wants it [R15]
					else
						scan_q <= scan_q + 1'b1;
				can_moh_pkg::RX_STORE:
					if (act_rx)
						rx_state_q <= can_moh_pkg::RX_IDLE;
				default:
					rx_state_q <= can_moh_pkg::RX_IDLE;
			endcase
		end
	end
endmodule // can_msg_handler

//--- testbench/can_msg_handler_sva.sv
// port assertions for the message handler
`timescale 1ns/1ps
module can_msg_handler_sva #(
	parameter int N_OBJ = 32
) (
	input wire logic             clk,
	input wire logic             reset_n,
	input wire logic [1:0]       if_req_we,
	input wire logic [1:0][5:0]  if_req_num,
	input wire logic [1:0]       if_busy,
	input wire logic             tx_ready,
	input wire logic             tx_ok,
	input wire logic             tx_fail,
	input wire logic             tx_load_q,
	input wire logic [28:0]      tx_id_q,
	input wire logic [63:0]      tx_data_q,
	input wire logic [N_OBJ-1:0] new_data_summary,
	input wire logic [N_OBJ-1:0] tx_request_summary,
	input wire logic [N_OBJ-1:0] object_valid_summary
);
	logic out_q;

	// frame in flight until the far side answers ok or fail
	always_ff @(posedge clk)
	begin
		if (!reset_n || tx_ok || tx_fail)
			out_q <= 1'b0;
		else if (tx_load_q)
			out_q <= 1'b1;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// requests that an idle set must take
	sequence s_take0;
		if_req_we[0] && !if_busy[0] && if_req_num[0] inside {[6'h01:6'h20]};
	endsequence
	sequence s_take1;
		if_req_we[1] && !if_busy[1] && if_req_num[1] inside {[6'h01:6'h20]};
	endsequence

	AST_LOAD_PULSE: assert property (tx_load_q |=> !tx_load_q)
		else $error("load strobe lasted more than one cycle");
	AST_LOAD_GATE: assert property (tx_load_q |-> $past(tx_ready) && $past(if_busy) == 2'b00
		&& ($past(tx_request_summary) & $past(object_valid_summary)) != '0)
		else $error("load without ready, idle sets and a valid request");
	AST_LOAD_SINGLE: assert property (tx_load_q |-> !out_q)
		else $error("second load before the first frame finished");
	AST_LOAD_NEW_DATA_FLAG: assert property (tx_load_q |->
		(new_data_summary & ~$past(new_data_summary)) == '0)
		else $error("new data flag rose at a load");
	AST_TX_HOLD: assert property (!tx_load_q |-> $stable(tx_id_q) && $stable(tx_data_q))
		else $error("frame fields changed without a load");
	AST_BUSY0_START: assert property (s_take0 |=> if_busy[0])
		else $error("set zero ignored a request");
	AST_BUSY1_START: assert property (s_take1 |=> if_busy[1])
		else $error("set one ignored a request");
	AST_BUSY0_END: assert property ($rose(if_busy[0]) |-> ##[1:6] !if_busy[0])
		else $error("set zero stayed busy too long");
endmodule // can_msg_handler_sva

bind can_msg_handler can_msg_handler_sva #(
	.N_OBJ(N_OBJ)
) i_sva (
	.*
);

//--- testbench/can_bus_model.sv
// far side model: takes loaded frames, answers them, sends received frames
`timescale 1ns/1ps
module can_bus_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        stall,
	input  wire logic        fail_next,
	input  wire logic        tx_load_q,
	output logic             tx_ready,
	output logic             tx_ok,
	output logic             tx_fail,
	output logic             rx_valid,
	output logic      [28:0] rx_id,
	output logic             rx_xtd,
	output logic             rx_rtr,
	output logic      [3:0]  rx_dlc,
	output logic      [63:0] rx_data
);
	logic       busy_q = 1'b0;
	logic [4:0] cnt_q = '0;

	// a frame in flight keeps the shift register full
	assign tx_ready = reset_n && !busy_q && !stall;

	initial
	begin
		{tx_ok, tx_fail, rx_valid, rx_xtd, rx_rtr} = '0;
		{rx_id, rx_dlc, rx_data} = '0;
	end

	// frame lasts twenty cycles, then one result pulse
	always @(posedge clk)
	begin
		tx_ok <= reset_n && busy_q && cnt_q == '0 && !tx_load_q && !fail_next;
		tx_fail <= reset_n && busy_q && cnt_q == '0 && !tx_load_q && fail_next;
		if (!reset_n)
			busy_q <= 1'b0;
		else if (tx_load_q)
		begin
			busy_q <= 1'b1;
			cnt_q <= 5'h14;
		end
		else if (busy_q && cnt_q == '0)
			busy_q <= 1'b0;
		else if (busy_q)
			cnt_q <= cnt_q - 5'h01;
	end

	// one received header and data; released lines flip so stale values cannot match
	task automatic send(input logic [28:0] id, input logic rtr, input logic [3:0] dlc,
		input logic [63:0] data);
		@(posedge clk);
		rx_valid <= 1'b1;
		{rx_id, rx_xtd, rx_rtr, rx_dlc, rx_data} <= {id, 1'b0, rtr, dlc, data};
		@(posedge clk);
		rx_valid <= 1'b0;
		{rx_id, rx_xtd, rx_rtr, rx_dlc, rx_data} <= ~{id, 1'b0, rtr, dlc, data};
		repeat (40) @(posedge clk);
		#1;
	endtask
endmodule // can_bus_model

//--- testbench/can_message_object_handler_tb.sv
// self-checking bench for the message object handler
`timescale 1ns/1ps
module can_message_object_handler_tb;
	logic             clk = 1'b0, reset_n = 1'b0, stall = 1'b1, fail_next = 1'b0;
	logic [1:0]       if_arb_we = '0, if_mask_we = '0, if_ctl_we = '0, if_dlo_we = '0;
	logic [1:0]       if_dhi_we = '0, if_cmd_we = '0, if_req_we = '0;
	logic [1:0][31:0] if_arb_wdata = '0, if_mask_wdata = '0, if_dlo_wdata = '0, if_dhi_wdata = '0;
	logic [1:0][15:0] if_ctl_wdata = '0, if_ctl;
	logic [1:0][7:0]  if_cmd_wdata = '0;
	logic [1:0][5:0]  if_req_num = '0;
	logic [1:0][31:0] if_arb, if_mask, if_dlo, if_dhi;
	logic [1:0]       if_busy;
	logic             tx_ready, tx_ok, tx_fail, tx_load_q, tx_xtd_q, tx_rtr_q;
	logic             rx_valid, rx_xtd, rx_rtr;
	logic [28:0]      tx_id_q, rx_id, ld_id[$];
	logic [3:0]       tx_dlc_q, rx_dlc;
	logic [63:0]      tx_data_q, rx_data, ld_data[$];
	logic [31:0]      new_data_summary, tx_request_summary, irq_pending_summary;
	logic [31:0]      message_lost_summary, object_valid_summary;
	int               fails = 0, check_count = 0, cycles = 0;

	can_msg_handler i_dut (.*, .if_cmd());
	can_bus_model i_bus (.*);

	always #20 clk = ~clk;

	// record each load, so a pulse during another wait is not lost
	always @(posedge clk)
	begin
		#1;
		if (tx_load_q === 1'b1)
		begin
			ld_id.push_back(tx_id_q);
			ld_data.push_back(tx_data_q);
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard: whole run needs about five hundred cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			test_done();
		end
	end

	// fill buffers, command, then object number; wait for the set to go idle
	task automatic xfer(input int k, input logic [5:0] num, input logic [7:0] cmd,
		input logic [31:0] arb, input logic [31:0] msk, input logic [15:0] ctl,
		input logic [63:0] data);
		int n;
		@(posedge clk);
		{if_arb_we[k], if_mask_we[k], if_ctl_we[k], if_dlo_we[k], if_dhi_we[k]} <= 5'h1f;
		{if_arb_wdata[k], if_mask_wdata[k], if_ctl_wdata[k]} <= {arb, msk, ctl};
		{if_dhi_wdata[k], if_dlo_wdata[k]} <= data;
		@(posedge clk);
		{if_arb_we, if_mask_we, if_ctl_we, if_dlo_we, if_dhi_we} <= '0;
		if_cmd_we[k] <= 1'b1;
		if_cmd_wdata[k] <= cmd;
		@(posedge clk);
		if_cmd_we[k] <= 1'b0;
		if_req_we[k] <= 1'b1;
		if_req_num[k] <= num;
		@(posedge clk);
		if_req_we[k] <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (if_busy[k] !== 1'b0 && n < 20);
		chk(if_busy[k], 1'b0);
	endtask

	task automatic wait_tx(input logic [10:0] id, input logic [63:0] data);
		int n;
		n = 0;
		while (ld_id.size() == 0 && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(ld_id.size() != 0, 1'b1);
		if (ld_id.size() != 0)
		begin
			chk(ld_id.pop_front(), {id, 18'h0_0000});
			chk(ld_data.pop_front(), data);
			chk({tx_xtd_q, tx_rtr_q, tx_dlc_q}, {2'b00, 4'h8});
		end
	endtask

	// wait for the frame result, then for its memory update to land
	task automatic wait_end();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (tx_ok !== 1'b1 && tx_fail !== 1'b1 && n < 60);
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic do_reset();
		@(posedge clk) reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		#1;
		chk(new_data_summary | tx_request_summary | irq_pending_summary, '0);
		chk(message_lost_summary | object_valid_summary, '0);
	endtask

	task automatic t_tx();
		xfer(0, 6'h05, 8'hf3, {3'b101, 11'h012, 18'h0_0000}, '0, 16'h8188, 64'h5555);
		xfer(1, 6'h02, 8'hf3, {3'b101, 11'h7f0, 18'h0_0000}, '0, 16'h8988, 64'h2222);
		@(posedge clk) stall <= 1'b0;
		wait_tx(11'h7f0, 64'h2222);
		chk(new_data_summary[1], 1'b0);
		wait_end();
		chk(tx_request_summary[1], 1'b0);
		chk({irq_pending_summary[4], irq_pending_summary[1]}, 2'b01);
		wait_tx(11'h012, 64'h5555);
		@(posedge clk) fail_next <= 1'b1;
		xfer(0, 6'h03, 8'hf3, {3'b101, 11'h400, 18'h0_0000}, '0, 16'h8188, 64'h3333);
		wait_end();
		@(posedge clk) fail_next <= 1'b0;
		wait_tx(11'h400, 64'h3333);
		xfer(1, 6'h03, 8'h87, '0, '0, '0, 64'h3a3a);
		wait_end();
		chk(tx_request_summary[2], 1'b1);
		wait_tx(11'h400, 64'h3a3a);
		chk(new_data_summary[2], 1'b0);
		wait_end();
		chk(tx_request_summary[2], 1'b0);
		wait_tx(11'h012, 64'h5555);
		wait_end();
		chk(tx_request_summary[4], 1'b0);
	endtask

	task automatic t_rx();
		xfer(0, 6'h07, 8'hf3, {3'b100, 11'h155, 18'h0_0000}, '0, 16'h0480, '0);
		xfer(0, 6'h09, 8'hf3, {3'b100, 11'h155, 18'h0_0000}, '0, 16'h0480, '0);
		i_bus.send({11'h155, 18'h0_0000}, 1'b0, 4'h6, 64'h1111_2222_3333_4444);
		chk({new_data_summary[8:6], message_lost_summary[6]}, 4'b0010);
		chk(irq_pending_summary[6], 1'b1);
		i_bus.send({11'h155, 18'h0_0000}, 1'b0, 4'h6, 64'h5555_6666_7777_8888);
		chk(message_lost_summary[6], 1'b1);
		xfer(1, 6'h07, 8'h7f, '0, '0, '0, '0);
		chk({if_dhi[1], if_dlo[1]}, 64'h5555_6666_7777_8888);
		chk({if_arb[1][28:0], if_ctl[1][3:0]}, {11'h155, 18'h0_0000, 4'h6});
		chk({new_data_summary[6], irq_pending_summary[6]}, 2'b00);
	endtask

	task automatic t_rmt();
		@(posedge clk) stall <= 1'b1;
		xfer(0, 6'h0a, 8'hf3, {3'b101, 11'h200, 18'h0_0000}, '0, 16'h0288, 64'h0a0a);
		xfer(0, 6'h0b, 8'hf3, {3'b101, 11'h210, 18'h0_0000}, '0, 16'h0188, 64'h0b0b);
		xfer(0, 6'h0c, 8'hf3, {3'b101, 11'h240, 18'h0_0000}, 32'h1ff8_0000, 16'h1188, 64'h0c0c);
		xfer(0, 6'h0d, 8'hf3, {3'b101, 11'h300, 18'h0_0000}, 32'h9ffc_0000, 16'h1288, 64'h0d0d);
		i_bus.send({11'h200, 18'h0_0000}, 1'b1, 4'h0, '0);
		i_bus.send({11'h210, 18'h0_0000}, 1'b1, 4'h0, '0);
		i_bus.send({11'h241, 18'h0_0000}, 1'b1, 4'h3, '0);
		i_bus.send({11'h300, 18'h0_0000}, 1'b1, 4'h0, '0);
		chk(tx_request_summary[12:9], 4'b0011);
		chk(new_data_summary[12:9], 4'b0100);
		xfer(1, 6'h0c, 8'h7f, '0, '0, '0, '0);
		chk({if_dlo[1], if_arb[1][28:18]}, {32'h0000_0c0c, 11'h241});
		chk(if_ctl[1][3:0], 4'h3);
		chk(if_mask[1], 32'h1ff8_0000);
	endtask

	initial
	begin
		do_reset();
		t_tx();
		t_rx();
		t_rmt();
		do_reset();
		test_done();
	end
endmodule // can_message_object_handler_tb
